/* File: host_bus_model.sv */
// External host processor on the parallel bus
`timescale 1ns/1ps

module host_bus_model
(
	// Clock
	input wire logic clk_i,
	// Bus towards the port
	output logic sel_o,
	output logic rd_o,
	output logic wr_o,
	output logic [3:0] addr_o,
	output logic [7:0] data_o,
	input wire logic [7:0] data_i
);
	initial
	begin
		sel_o = 1'b0;
		rd_o = 1'b0;
		wr_o = 1'b0;
		addr_o = 4'h0;
		data_o = 8'h00;
	end

	// Strobe stands 6 cycles: the port accepts after about 3
	task automatic xfer(input logic w, input logic [3:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge clk_i);
		sel_o <= 1'b1;
		rd_o <= !w;
		wr_o <= w;
		addr_o <= a;
		data_o <= d;
		repeat (6) @(posedge clk_i);
		q = data_i;
		sel_o <= 1'b0;
		rd_o <= 1'b0;
		wr_o <= 1'b0;
		addr_o <= ~a;
		data_o <= ~d;
		// Gap long enough for the drop to pass the synchronisers
		repeat (6) @(posedge clk_i);
	endtask
endmodule

/* File: uart_emulation_host_port.sv */
// Dual-port host interface emulating a serial-controller register set
`timescale 1ns/1ps

module uart_emulation_host_port
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// Host bus pins
	input wire logic host_sel_i,
	input wire logic host_rd_i,
	input wire logic host_wr_i,
	input wire logic [3:0] host_addr_i,
	input wire logic [7:0] host_data_i,
	output logic [7:0] host_data_o,
	output logic host_data_oe_o,
	output logic host_interrupt_out_o,
	output logic host_interrupt_out_oe_o,
	// Internal CPU port
	input wire logic [7:0] cpu_addr_i,
	input wire logic cpu_rd_i,
	input wire logic cpu_wr_i,
	input wire logic [7:0] cpu_wdata_i,
	output logic [7:0] cpu_rdata_o,
	output logic cpu_host_port_irq_o,
	// Shared pin ownership
	output logic host_pins_enable_o
);

	// ----------------------------------------------------------------
	// Host pin synchronisers
	// ----------------------------------------------------------------
	// Strobes are qualified before sampling; a change is accepted only
	// once the second and third stages agree.
	logic [1:0] strb_s1;
	logic [1:0] strb_s2;
	logic [1:0] strb_s3;
	logic [1:0] strb_lvl;
	logic [3:0] addr_s1;
	logic [3:0] addr_s2;
	logic [3:0] addr_s3;
	logic [7:0] data_s1;
	logic [7:0] data_s2;
	logic [7:0] data_s3;
	logic [1:0] strb_agree;
	logic host_rd_go;
	logic host_wr_go;

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			strb_s1 <= 2'h0;
			strb_s2 <= 2'h0;
			strb_s3 <= 2'h0;
		end
		else
		begin
			strb_s1 <= {host_sel_i & host_wr_i, host_sel_i & host_rd_i};
			strb_s2 <= strb_s1;
			strb_s3 <= strb_s2;
		end
	end

	always_ff @(posedge clk_i)
	begin
		addr_s1 <= host_addr_i;
		addr_s2 <= addr_s1;
		addr_s3 <= addr_s2;
		data_s1 <= host_data_i;
		data_s2 <= data_s1;
		data_s3 <= data_s2;
	end

	assign strb_agree = ~(strb_s2 ^ strb_s3);

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			strb_lvl <= 2'h0;
		else
			strb_lvl <= (strb_lvl & ~strb_agree) | (strb_s3 & strb_agree);
	end

	// ----------------------------------------------------------------
	// Modes
	// ----------------------------------------------------------------
	logic [2:0] hpc_ctrl;
	logic [3:0] hpc_flag;
	logic host_en;
	logic emul_mode;

	assign host_en = hpc_ctrl[uart_emulation_host_port_pkg::HPC_HOST_EN];
	assign emul_mode = host_en
		& hpc_ctrl[uart_emulation_host_port_pkg::HPC_MODE_SEL];
	// Host accesses only count while the pins belong to the host
	assign host_rd_go = host_en & strb_agree[0] & strb_s3[0] & ~strb_lvl[0];
	assign host_wr_go = host_en & strb_agree[1] & strb_s3[1] & ~strb_lvl[1];

	// ----------------------------------------------------------------
	// Host access decode
	// ----------------------------------------------------------------
	logic div_access;
	logic [2:0] hloc;
	logic emul_rd;
	logic emul_wr;
	logic rd_rx;
	logic wr_tx;
	logic wr_div;
	logic wr_ier;
	logic rd_ident;
	logic wr_lcr;
	logic wr_mcr;
	logic rd_lsr;
	logic wr_lsr;
	logic rd_msr;
	logic wr_msr;

	assign hloc = addr_s3[2:0];
	assign emul_rd = host_rd_go & emul_mode;
	assign emul_wr = host_wr_go & emul_mode;
	// Divisor access bit redirects locations 0 and 1
	assign rd_rx = emul_rd & ~div_access
		& (hloc == uart_emulation_host_port_pkg::HOST_DATA);
	assign wr_tx = emul_wr & ~div_access
		& (hloc == uart_emulation_host_port_pkg::HOST_DATA);
	assign wr_div = emul_wr & div_access
		& ((hloc == uart_emulation_host_port_pkg::HOST_DATA)
		| (hloc == uart_emulation_host_port_pkg::HOST_IRQ_ENABLE));
	assign wr_ier = emul_wr & ~div_access
		& (hloc == uart_emulation_host_port_pkg::HOST_IRQ_ENABLE);
	assign rd_ident = emul_rd
		& (hloc == uart_emulation_host_port_pkg::HOST_IDENT);
	assign wr_lcr = emul_wr
		& (hloc == uart_emulation_host_port_pkg::HOST_LINE_CONTROL);
	assign wr_mcr = emul_wr
		& (hloc == uart_emulation_host_port_pkg::HOST_MODEM_CONTROL);
	assign rd_lsr = emul_rd
		& (hloc == uart_emulation_host_port_pkg::HOST_LINE_STATUS);
	assign wr_lsr = emul_wr
		& (hloc == uart_emulation_host_port_pkg::HOST_LINE_STATUS);
	assign rd_msr = emul_rd
		& (hloc == uart_emulation_host_port_pkg::HOST_MODEM_STATUS);
	assign wr_msr = emul_wr
		& (hloc == uart_emulation_host_port_pkg::HOST_MODEM_STATUS);

	// ----------------------------------------------------------------
	// CPU access decode
	// ----------------------------------------------------------------
	logic cpu_in_ram;
	logic cpu_wr_lsr;
	logic cpu_wr_msr;
	logic cpu_wr_hpc;

	assign cpu_in_ram = cpu_addr_i[7:4] == uart_emulation_host_port_pkg::RAM_BASE_PAGE;
	assign cpu_wr_lsr = cpu_wr_i
		& (cpu_addr_i == uart_emulation_host_port_pkg::LINE_STATUS);
	assign cpu_wr_msr = cpu_wr_i
		& (cpu_addr_i == uart_emulation_host_port_pkg::MODEM_STATUS);
	assign cpu_wr_hpc = cpu_wr_i
		& (cpu_addr_i == uart_emulation_host_port_pkg::HOST_PORT_CONTROL);

	// ----------------------------------------------------------------
	// Shared memory window
	// ----------------------------------------------------------------
	// Not reset: buffers and line control keep whatever was there.
	logic [7:0] ram [0:uart_emulation_host_port_pkg::RAM_WORDS-1];
	logic host_ram_wr;
	logic [3:0] host_ram_idx;

	always_comb
	begin
		host_ram_wr = 1'b0;
		host_ram_idx = addr_s3;
		if (host_wr_go & ~emul_mode)
			host_ram_wr = 1'b1;
		else if (emul_wr)
		begin
			case (hloc)
				uart_emulation_host_port_pkg::HOST_DATA:
				begin
					host_ram_wr = 1'b1;
					host_ram_idx = div_access
						? uart_emulation_host_port_pkg::BAUD_DIVISOR_LOW[3:0]
						: uart_emulation_host_port_pkg::TRANSMIT_BUFFER[3:0];
				end
				uart_emulation_host_port_pkg::HOST_IRQ_ENABLE:
				begin
					host_ram_wr = div_access;
					host_ram_idx = uart_emulation_host_port_pkg::BAUD_DIVISOR_HIGH[3:0];
				end
				uart_emulation_host_port_pkg::HOST_LINE_CONTROL:
				begin
					host_ram_wr = 1'b1;
					host_ram_idx = uart_emulation_host_port_pkg::LINE_CONTROL[3:0];
				end
				uart_emulation_host_port_pkg::HOST_MODEM_CONTROL:
				begin
					host_ram_wr = 1'b1;
					host_ram_idx = uart_emulation_host_port_pkg::MODEM_CONTROL[3:0];
				end
				uart_emulation_host_port_pkg::HOST_SCRATCH:
				begin
					host_ram_wr = 1'b1;
					host_ram_idx = {1'b0, uart_emulation_host_port_pkg::HOST_SCRATCH};
				end
				default:
					host_ram_wr = 1'b0;
			endcase
		end
	end

	// Host wins a same-cycle collision on one location
	always_ff @(posedge clk_i)
	begin
		if (cpu_wr_i & cpu_in_ram & ~(host_ram_wr & (host_ram_idx == cpu_addr_i[3:0])))
			ram[cpu_addr_i[3:0]] <= cpu_wdata_i;
		if (host_ram_wr)
			ram[host_ram_idx] <= data_s3;
	end

	// Separate latch; the CPU cannot move the host's address extension
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			div_access <= 1'b0;
		else if (wr_lcr)
			div_access <= data_s3[uart_emulation_host_port_pkg::LC_DIV_ACCESS];
	end

	// ----------------------------------------------------------------
	// Host control register
	// ----------------------------------------------------------------
	logic [3:0] flag_set;
	logic [3:0] flag_clr;

	assign flag_set = {wr_tx, wr_mcr, wr_lcr, wr_div};
	assign flag_clr = cpu_wr_hpc ? ~cpu_wdata_i[7:4] : 4'h0;

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			hpc_ctrl <= uart_emulation_host_port_pkg::HPC_CTRL_RESET;
			hpc_flag <= uart_emulation_host_port_pkg::HPC_FLAG_RESET;
		end
		else
		begin
			if (cpu_wr_hpc)
				hpc_ctrl <= cpu_wdata_i[2:0];
			// A host event in the clearing cycle is kept
			hpc_flag <= (hpc_flag & ~flag_clr) | flag_set;
		end
	end

	// ----------------------------------------------------------------
	// Line and modem status, interrupt enables
	// ----------------------------------------------------------------
	logic [6:0] line_status;
	logic [7:0] modem_status;
	logic [3:0] host_interrupt_enable;
	logic [6:0] next_lsr;
	logic [7:0] next_msr;
	logic tx_armed;
	logic tx_is_cause;

	always_comb
	begin
		next_lsr = line_status;
		if (wr_lsr)
			next_lsr = data_s3[6:0];
		if (rd_lsr)
			next_lsr[4:1] = 4'h0;
		if (rd_rx)
			next_lsr[uart_emulation_host_port_pkg::LS_DATA_READY] = 1'b0;
		if (wr_tx)
		begin
			next_lsr[uart_emulation_host_port_pkg::LS_TX_HOLD_EMPTY] = 1'b0;
			next_lsr[uart_emulation_host_port_pkg::LS_TX_EMPTY] = 1'b0;
		end
		// CPU sets bits by writing zeros; the set beats any clear
		if (cpu_wr_lsr)
			next_lsr = next_lsr | ~cpu_wdata_i[6:0];
	end

	always_comb
	begin
		next_msr = modem_status;
		if (wr_msr)
			next_msr[7:4] = data_s3[7:4];
		if (rd_msr)
			next_msr[3:0] = 4'h0;
		if (cpu_wr_msr)
		begin
			next_msr[7:4] = cpu_wdata_i[7:4];
			next_msr[3:0] = next_msr[3:0] | ~cpu_wdata_i[3:0];
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			line_status <= uart_emulation_host_port_pkg::LINE_STATUS_RESET;
			modem_status <= uart_emulation_host_port_pkg::MODEM_STATUS_RESET;
		end
		else
		begin
			line_status <= next_lsr;
			modem_status <= next_msr;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			host_interrupt_enable <= uart_emulation_host_port_pkg::IRQ_ENABLE_RESET;
		else if (wr_ier)
			host_interrupt_enable <= data_s3[3:0];
	end

	// Transmit-empty cause: armed when the CPU raises holding-empty
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			tx_armed <= 1'b0;
		else if (cpu_wr_lsr & ~cpu_wdata_i[uart_emulation_host_port_pkg::LS_TX_HOLD_EMPTY])
			tx_armed <= 1'b1;
		else if (wr_tx | (rd_ident & tx_is_cause))
			tx_armed <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Interrupt identification
	// ----------------------------------------------------------------
	logic src_line;
	logic src_rx;
	logic src_tx;
	logic src_modem;
	logic any_pending;
	logic [1:0] live_code;
	logic held;
	logic [1:0] held_code;
	logic held_pending;
	logic [7:0] ident_val;

	assign src_rx = host_interrupt_enable[0] & line_status[uart_emulation_host_port_pkg::LS_DATA_READY];
	assign src_tx = host_interrupt_enable[1] & tx_armed
		& line_status[uart_emulation_host_port_pkg::LS_TX_HOLD_EMPTY];
	assign src_line = host_interrupt_enable[2] & (|line_status[4:1]);
	assign src_modem = host_interrupt_enable[3] & (|modem_status[3:0]);
	assign any_pending = src_line | src_rx | src_tx | src_modem;

	always_comb
	begin
		if (src_line)
			live_code = uart_emulation_host_port_pkg::IDENT_LINE;
		else if (src_rx)
			live_code = uart_emulation_host_port_pkg::IDENT_RX;
		else if (src_tx)
			live_code = uart_emulation_host_port_pkg::IDENT_TX;
		else
			live_code = uart_emulation_host_port_pkg::IDENT_MODEM;
	end

	always_comb
	begin
		case (held_code)
			uart_emulation_host_port_pkg::IDENT_LINE:
				held_pending = src_line;
			uart_emulation_host_port_pkg::IDENT_RX:
				held_pending = src_rx;
			uart_emulation_host_port_pkg::IDENT_TX:
				held_pending = src_tx;
			default:
				held_pending = src_modem;
		endcase
	end

	// Frozen report survives until its own source is serviced
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			held <= 1'b0;
			held_code <= uart_emulation_host_port_pkg::IDENT_MODEM;
		end
		else if (held & ~held_pending)
			held <= 1'b0;
		else if (rd_ident & ~held & any_pending)
		begin
			held <= 1'b1;
			held_code <= live_code;
		end
	end

	always_comb
	begin
		if (held & held_pending)
			ident_val = {5'h00, held_code, 1'b0};
		else if (any_pending)
			ident_val = {5'h00, live_code, 1'b0};
		else
			ident_val = uart_emulation_host_port_pkg::IDENT_NONE;
	end

	assign tx_is_cause = ident_val[2:0]
		== {uart_emulation_host_port_pkg::IDENT_TX, 1'b0};

	// ----------------------------------------------------------------
	// Host read data and pin drive
	// ----------------------------------------------------------------
	logic [7:0] host_rd_val;
	logic [7:0] mcr_val;
	logic [7:0] lcr_val;

	assign mcr_val = ram[uart_emulation_host_port_pkg::MODEM_CONTROL[3:0]];
	assign lcr_val = ram[uart_emulation_host_port_pkg::LINE_CONTROL[3:0]];

	always_comb
	begin
		host_rd_val = ram[addr_s3];
		if (emul_mode)
		begin
			case (hloc)
				uart_emulation_host_port_pkg::HOST_DATA:
					host_rd_val = div_access
						? ram[uart_emulation_host_port_pkg::BAUD_DIVISOR_LOW[3:0]]
						: ram[uart_emulation_host_port_pkg::RECEIVE_BUFFER[3:0]];
				uart_emulation_host_port_pkg::HOST_IRQ_ENABLE:
					host_rd_val = div_access
						? ram[uart_emulation_host_port_pkg::BAUD_DIVISOR_HIGH[3:0]]
						: {4'h0, host_interrupt_enable};
				uart_emulation_host_port_pkg::HOST_IDENT:
					host_rd_val = ident_val;
				uart_emulation_host_port_pkg::HOST_LINE_CONTROL:
					host_rd_val = {div_access, lcr_val[6:0]};
				uart_emulation_host_port_pkg::HOST_MODEM_CONTROL:
					host_rd_val = mcr_val;
				uart_emulation_host_port_pkg::HOST_LINE_STATUS:
					host_rd_val = {1'b0, line_status};
				uart_emulation_host_port_pkg::HOST_MODEM_STATUS:
					host_rd_val = mcr_val[uart_emulation_host_port_pkg::MC_LOOP]
						? {mcr_val[3], mcr_val[2], mcr_val[0], mcr_val[1], modem_status[3:0]}
						: modem_status;
				default:
					host_rd_val = ram[{1'b0, uart_emulation_host_port_pkg::HOST_SCRATCH}];
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			host_data_o <= 8'h00;
			host_data_oe_o <= 1'b0;
		end
		else
		begin
			if (host_rd_go)
				host_data_o <= host_rd_val;
			// Drive for as long as the accepted read strobe stands
			host_data_oe_o <= host_en
				& (strb_agree[0] ? strb_s3[0] : strb_lvl[0]);
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			host_interrupt_out_o <= 1'b0;
			host_interrupt_out_oe_o <= 1'b0;
		end
		else
		begin
			host_interrupt_out_o <= emul_mode & any_pending;
			host_interrupt_out_oe_o <= emul_mode
				& mcr_val[uart_emulation_host_port_pkg::MC_OUT2];
		end
	end

	// ----------------------------------------------------------------
	// CPU read data and CPU interrupt
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			cpu_rdata_o <= 8'h00;
		else if (cpu_rd_i)
		begin
			if (cpu_in_ram)
				cpu_rdata_o <= ram[cpu_addr_i[3:0]];
			else if (cpu_addr_i == uart_emulation_host_port_pkg::LINE_STATUS)
				cpu_rdata_o <= {1'b0, line_status};
			else if (cpu_addr_i == uart_emulation_host_port_pkg::MODEM_STATUS)
				cpu_rdata_o <= modem_status;
			else if (cpu_addr_i == uart_emulation_host_port_pkg::HOST_PORT_CONTROL)
				cpu_rdata_o <= {hpc_flag, 1'b1, hpc_ctrl};
			else
				cpu_rdata_o <= 8'h00;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			cpu_host_port_irq_o <= 1'b0;
			host_pins_enable_o <= 1'b0;
		end
		else
		begin
			cpu_host_port_irq_o <= hpc_ctrl[uart_emulation_host_port_pkg::HPC_IRQ_EN]
				& (|hpc_flag);
			host_pins_enable_o <= host_en;
		end
	end

endmodule

/* File: uart_emulation_host_port_asserts.sv */
// Checker for the emulated serial-controller host port
`timescale 1ns/1ps

module uart_emulation_host_port_asserts
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// CPU port
	input wire logic [7:0] cpu_addr_i,
	input wire logic cpu_rd_i,
	input wire logic cpu_wr_i,
	input wire logic [7:0] cpu_wdata_i,
	input wire logic [7:0] cpu_rdata_o,
	input wire logic cpu_host_port_irq_o,
	// Host side
	input wire logic host_data_oe_o,
	input wire logic host_interrupt_out_o,
	input wire logic host_pins_enable_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);

	logic [2:0] ctl_low;
	logic ctl_wr;

	assign ctl_wr = cpu_wr_i
		&& cpu_addr_i == uart_emulation_host_port_pkg::HOST_PORT_CONTROL;

	// Host writes never touch bits 2:0, so CPU writes alone predict them
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			ctl_low <= 3'h0;
		else if (ctl_wr)
			ctl_low <= cpu_wdata_i[2:0];
	end

	// ---
	// Properties
	// ---
	a_reset_quiet: assert property ($fell(srst_i) |->
		!host_pins_enable_o && !cpu_host_port_irq_o && !host_data_oe_o)
		else $error("outputs not idle after reset");
	a_ctl_readback: assert property (cpu_rd_i && !cpu_wr_i &&
		cpu_addr_i == uart_emulation_host_port_pkg::HOST_PORT_CONTROL
		|=> cpu_rdata_o[3:0] == {1'b1, ctl_low})
		else $error("control low bits read wrong");
	a_pins_follow: assert property (ctl_wr |=> ##1
		host_pins_enable_o == $past(cpu_wdata_i[2], 2))
		else $error("pin ownership not following control");
	a_irq_gated: assert property (ctl_wr && !cpu_wdata_i[0] |=> ##1
		!cpu_host_port_irq_o) else $error("cpu irq while disabled");
	// Output lags the enable by one edge, so look one cycle back
	a_irq_cause: assert property ($rose(cpu_host_port_irq_o) |->
		$past(ctl_low[0])) else $error("cpu irq without enable");
	a_plain_quiet: assert property (ctl_wr && !cpu_wdata_i[1] |=> ##1
		!host_interrupt_out_o) else $error("host irq in plain mode");
	a_read_owner: assert property (host_data_oe_o |->
		host_pins_enable_o) else $error("host read without host mode");
	a_unmapped_zero: assert property (cpu_rd_i &&
		(cpu_addr_i < uart_emulation_host_port_pkg::RECEIVE_BUFFER
		|| cpu_addr_i > uart_emulation_host_port_pkg::HOST_PORT_CONTROL)
		|=> cpu_rdata_o == 8'h00)
		else $error("unmapped cpu read not zero");

	c_cpu_irq: cover property ($rose(cpu_host_port_irq_o));
	c_host_irq: cover property ($rose(host_interrupt_out_o));
	c_host_read: cover property ($rose(host_data_oe_o));
endmodule

bind uart_emulation_host_port uart_emulation_host_port_asserts u_chk
(
	.clk_i,
	.srst_i,
	.cpu_addr_i,
	.cpu_rd_i,
	.cpu_wr_i,
	.cpu_wdata_i,
	.cpu_rdata_o,
	.cpu_host_port_irq_o,
	.host_data_oe_o,
	.host_interrupt_out_o,
	.host_pins_enable_o
);

/* File: uart_emulation_host_port_bench.sv */
// Self-checking bench for the emulated serial-controller host port
`timescale 1ns/1ps

module uart_emulation_host_port_bench;
	// ---
	// Signals
	// ---
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic cpu_rd_i = 1'b0;
	logic cpu_wr_i = 1'b0;
	logic [7:0] cpu_addr_i = 8'h00;
	logic [7:0] cpu_wdata_i = 8'h00;
	logic host_sel_i, host_rd_i, host_wr_i;
	logic [3:0] host_addr_i;
	logic [7:0] host_data_i, host_data_o, cpu_rdata_o, host_seen;
	logic host_data_oe_o, host_interrupt_out_o, host_interrupt_out_oe_o;
	logic cpu_host_port_irq_o, host_pins_enable_o;
	int bad_count = 0;
	int samples_checked = 0;

	// Undriven bus shows the inverse, never a stale copy
	assign host_seen = host_data_oe_o ? host_data_o : ~host_data_i;
	always #25 clk_i = ~clk_i;

	uart_emulation_host_port u_dut
	(
		.clk_i,
		.srst_i,
		.host_sel_i,
		.host_rd_i,
		.host_wr_i,
		.host_addr_i,
		.host_data_i,
		.host_data_o,
		.host_data_oe_o,
		.host_interrupt_out_o,
		.host_interrupt_out_oe_o,
		.cpu_addr_i,
		.cpu_rd_i,
		.cpu_wr_i,
		.cpu_wdata_i,
		.cpu_rdata_o,
		.cpu_host_port_irq_o,
		.host_pins_enable_o
	);

	host_bus_model u_host
	(
		.clk_i,
		.sel_o(host_sel_i),
		.rd_o(host_rd_i),
		.wr_o(host_wr_i),
		.addr_o(host_addr_i),
		.data_o(host_data_i),
		.data_i(host_seen)
	);

	// ---
	// Access tasks
	// ---
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cw(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		cpu_wr_i <= 1'b1;
		cpu_addr_i <= a;
		cpu_wdata_i <= d;
		@(posedge clk_i);
		cpu_wr_i <= 1'b0;
	endtask

	task automatic crk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_i);
		cpu_rd_i <= 1'b1;
		cpu_addr_i <= a;
		@(posedge clk_i);
		cpu_rd_i <= 1'b0;
		#1 chk(cpu_rdata_o, e);
	endtask

	task automatic hw(input logic [3:0] a, input logic [7:0] d);
		logic [7:0] q;
		u_host.xfer(1'b1, a, d, q);
	endtask

	task automatic hr(input logic [3:0] a, input logic [7:0] e);
		logic [7:0] q;
		u_host.xfer(1'b0, a, 8'h00, q);
		chk(q, e);
	endtask

	task automatic close_out;
		if (bad_count == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Roughly five times the expected run
	initial
	begin
		#100000;
		bad_count++;
		close_out;
	end

	// ---
	// Tests
	// ---
	initial
	begin
		repeat (3) @(posedge clk_i);
		srst_i <= 1'b0;
		crk(8'h32, 8'h08);
		cw(8'h27, 8'h22);
		cw(8'h32, 8'h03);
		hw(4'h7, 8'h11);
		crk(8'h27, 8'h22);
		chk(host_pins_enable_o, 8'h00);
		cw(8'h21, 8'h5a);
		cw(8'h32, 8'h05);
		hr(4'h1, 8'h5a);
		cw(8'h32, 8'hff);
		crk(8'h32, 8'h0f);
		chk(host_pins_enable_o, 8'h01);
		chk(cpu_host_port_irq_o, 8'h00);
		hw(4'h3, 8'h80);
		crk(8'h32, 8'h2f);
		chk(cpu_host_port_irq_o, 8'h01);
		hw(4'h0, 8'h34);
		crk(8'h28, 8'h34);
		crk(8'h32, 8'h3f);
		hw(4'h1, 8'h12);
		crk(8'h29, 8'h12);
		hw(4'h3, 8'h03);
		hw(4'h4, 8'h08);
		crk(8'h32, 8'h7f);
		chk(host_interrupt_out_oe_o, 8'h01);
		hw(4'h0, 8'h5a);
		crk(8'h21, 8'h5a);
		crk(8'h32, 8'hff);
		cw(8'h32, 8'hf6);
		crk(8'h32, 8'hfe);
		chk(cpu_host_port_irq_o, 8'h00);
		cw(8'h32, 8'h07);
		crk(8'h32, 8'h0f);
		cw(8'h20, 8'ha5);
		cw(8'h30, 8'hfe);
		hr(4'h5, 8'h01);
		hr(4'h1, 8'h00);
		hr(4'h2, 8'h01);
		chk(host_interrupt_out_o, 8'h00);
		hw(4'h1, 8'hff);
		hr(4'h1, 8'h0f);
		chk(host_interrupt_out_o, 8'h01);
		hr(4'h2, 8'h04);
		hr(4'h0, 8'ha5);
		chk(host_interrupt_out_o, 8'h00);
		hr(4'h2, 8'h01);
		cw(8'h31, 8'hfe);
		hr(4'h2, 8'h00);
		cw(8'h30, 8'hfd);
		hr(4'h2, 8'h00);
		hr(4'h6, 8'hf1);
		hr(4'h2, 8'h06);
		hr(4'h5, 8'h02);
		cw(8'h30, 8'hdf);
		hr(4'h2, 8'h02);
		chk(host_interrupt_out_o, 8'h00);
		hw(4'h2, 8'hff);
		hr(4'h2, 8'h01);
		hw(4'h4, 8'h08);
		crk(8'h32, 8'h4f);
		// Mid-run reset must drop the flags and hand the pins back
		@(posedge clk_i);
		srst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		srst_i <= 1'b0;
		crk(8'h32, 8'h08);
		chk(cpu_host_port_irq_o, 8'h00);
		chk(host_pins_enable_o, 8'h00);
		chk(host_interrupt_out_oe_o, 8'h00);
		crk(8'h40, 8'h00);
		close_out;
	end
endmodule

/* File: uart_emulation_host_port_pkg.sv */
// Constants for the emulated serial-controller host port
package uart_emulation_host_port_pkg;

	// ----------------------------------------------------------------
	// CPU-side addresses in the shared dual-port window and of the port registers
	// ----------------------------------------------------------------
	localparam logic [7:0] RECEIVE_BUFFER = 8'h20;
	localparam logic [7:0] TRANSMIT_BUFFER = 8'h21;
	localparam logic [7:0] LINE_CONTROL = 8'h23;
	localparam logic [7:0] MODEM_CONTROL = 8'h24;
	localparam logic [7:0] BAUD_DIVISOR_LOW = 8'h28;
	localparam logic [7:0] BAUD_DIVISOR_HIGH = 8'h29;
	localparam logic [7:0] HANDSHAKE_FLAGS = 8'h2f;
	localparam logic [7:0] LINE_STATUS = 8'h30;
	localparam logic [7:0] MODEM_STATUS = 8'h31;
	localparam logic [7:0] HOST_PORT_CONTROL = 8'h32;
	localparam logic [3:0] RAM_BASE_PAGE = 4'h2;
	localparam int RAM_WORDS = 16;

	// ----------------------------------------------------------------
	// Host locations in serial-controller emulation mode
	// ----------------------------------------------------------------
	localparam logic [2:0] HOST_DATA = 3'h0;
	localparam logic [2:0] HOST_IRQ_ENABLE = 3'h1;
	localparam logic [2:0] HOST_IDENT = 3'h2;
	localparam logic [2:0] HOST_LINE_CONTROL = 3'h3;
	localparam logic [2:0] HOST_MODEM_CONTROL = 3'h4;
	localparam logic [2:0] HOST_LINE_STATUS = 3'h5;
	localparam logic [2:0] HOST_MODEM_STATUS = 3'h6;
	localparam logic [2:0] HOST_SCRATCH = 3'h7;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int HPC_IRQ_EN = 0;
	localparam int HPC_MODE_SEL = 1;
	localparam int HPC_HOST_EN = 2;
	localparam int HPC_DIV_FLAG = 4;
	localparam int HPC_LCR_FLAG = 5;
	localparam int HPC_MCR_FLAG = 6;
	localparam int HPC_TX_FULL = 7;
	localparam int LS_DATA_READY = 0;
	localparam int LS_TX_HOLD_EMPTY = 5;
	localparam int LS_TX_EMPTY = 6;
	localparam int MC_OUT2 = 3;
	localparam int MC_LOOP = 4;
	localparam int LC_DIV_ACCESS = 7;

	// ----------------------------------------------------------------
	// Identification codes and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] IDENT_LINE = 2'h3;
	localparam logic [1:0] IDENT_RX = 2'h2;
	localparam logic [1:0] IDENT_TX = 2'h1;
	localparam logic [1:0] IDENT_MODEM = 2'h0;
	localparam logic [7:0] IDENT_NONE = 8'h01;
	localparam logic [2:0] HPC_CTRL_RESET = 3'h0;
	localparam logic [3:0] HPC_FLAG_RESET = 4'h0;
	localparam logic [3:0] IRQ_ENABLE_RESET = 4'h0;
	localparam logic [6:0] LINE_STATUS_RESET = 7'h00;
	localparam logic [7:0] MODEM_STATUS_RESET = 8'h00;

endpackage
